/* File: rcl_loader.v */
// reset configuration byte loader with apb access to the configuration register
//
// Function
// - each rising edge of the external reset line while no fetch runs fetches the byte at 00fff3h into the config register.
// - the fetch uses internal rom when the strap is low and the external bus when it is high.
// - after an internal reset a reset pulse is driven out, 4095 clocks long when the length bit is 1, else 16.
// - with strap high the first pulse after power-on is short and later ones follow the length bit.
// - with strap low every pulse is long.
// - the shared pins are in bus mode unless pin mode is set or toggle is set with the strap high.
// - program storage is internal rom, test rom or the external bus according to the two rom bits.
// - the hardware option bytes 00ffa0h to 00ffc3h cannot be changed by software.
//
// register map, one aligned word per register on the apb side:
//   0x000 config register, read/write between reset releases
//   0x004 status, read only: {pulse active, loaded, fetched over bus, bus mode, storage select}
//   0x008 option index, 0 to 35
//   0x00c option data, read only: a read returns the byte of the previous fetch
//         and starts a fetch of the indexed byte, so software reads it twice
//   any other offset answers with pslverr and reads as zero
// limitation: software writes that land while a fetch runs are dropped, the fetch wins
// the fetch waits on mem_ack with no timeout, so storage that never answers stalls it
// the strap pin passes two flops, so it must settle before the reset line rises
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "rcl_defs.vh"
module rcl_loader #(
    parameter LONG_CYC = 4095,
    parameter SHORT_CYC = 16
) (
    input wire ref_clk,
    input wire nrst,
    input wire reset_line_in,
    output reg reset_line_oe,
    input wire internal_reset_req,
    input wire strap_select,
    output reg [23:0] mem_addr,
    output reg mem_rd_int,
    output reg mem_rd_ext,
    input wire mem_ack,
    input wire [7:0] mem_rdata,
    output wire bus_mode,
    output wire [1:0] storage_sel,
    output wire onchip_ram_enable,
    output wire onchip_cpu_enable,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    // fetch sequencer states
    localparam ST_IDLE = 2'd0;
    localparam ST_FETCH = 2'd1;
    localparam ST_OPT = 2'd2;
    // pulse lengths cut to the counter width on purpose
    localparam [12:0] LONG_N = LONG_CYC[12:0];
    localparam [12:0] SHORT_N = SHORT_CYC[12:0];

    // synchronised pins and edge history
    reg [1:0] rst_sync_ff;
    reg [1:0] strap_sync_ff;
    reg rst_prev_ff;

    // config register and fetch sequencer
    reg [7:0] cfg_ff;
    reg [1:0] state_ff;
    reg fetch_ext_ff;
    reg loaded_ff;

    // outgoing reset pulse
    reg [12:0] pulse_cnt_ff;
    reg first_pulse_ff;

    // option byte read port
    reg [5:0] opt_idx_ff;
    reg [7:0] opt_data_ff;

    // synchronised pin levels; only the second stage is read
    wire rst_line = rst_sync_ff[1];
    wire strap = strap_sync_ff[1];
    // reset line release, seen in the same cycle the synchroniser output rises
    wire rise = rst_line & ~rst_prev_ff;
    // apb decode
    wire wr = psel & penable & pwrite;
    wire rd = psel & ~pwrite;
    wire opt_rd_access = psel & penable & ~pwrite & (paddr == `RCL_OFF_OPTDATA);
    wire hit = (paddr == `RCL_OFF_CFG) | (paddr == `RCL_OFF_STAT) |
               (paddr == `RCL_OFF_OPTADDR) | (paddr == `RCL_OFF_OPTDATA);
    // an index past the last option byte fetches nothing
    wire opt_valid = (opt_idx_ff <= `RCL_OPT_LAST);

    // two-flop synchronisers for pins
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_ff <= 2'b00;
            strap_sync_ff <= 2'b00;
            rst_prev_ff <= 1'b0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], reset_line_in};
            strap_sync_ff <= {strap_sync_ff[0], strap_select};
            rst_prev_ff <= rst_line;
        end
    end

    // mode decode from config bits
    assign bus_mode = ~cfg_ff[`RCL_BIT_MODE] & ~(cfg_ff[`RCL_BIT_TOG] & strap);
    // 2'd0 internal rom, 2'd1 test rom, 2'd2 external bus
    assign storage_sel = ~cfg_ff[`RCL_BIT_ONCHIP_ROM_SELECT] ? 2'd2 :
                         (cfg_ff[`RCL_BIT_FROM] ? 2'd0 : 2'd1);
    // enables pass straight through from the config bits
    assign onchip_ram_enable = cfg_ff[`RCL_BIT_ONCHIP_RAM_ENABLE];
    assign onchip_cpu_enable = cfg_ff[`RCL_BIT_ONCHIP_CPU_ENABLE];
    // an option read that arrives while an option fetch runs waits; the ack ends the wait
    assign pready = ~(opt_rd_access & (state_ff == ST_OPT)) | mem_ack;
    // unmapped offsets are refused
    assign pslverr = psel & penable & ~hit;

    // fetch sequencer, option read port and config register
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            cfg_ff <= `RCL_CFG_RST;
            mem_addr <= 24'h000000;
            mem_rd_int <= 1'b0;
            mem_rd_ext <= 1'b0;
            fetch_ext_ff <= 1'b0;
            loaded_ff <= 1'b0;
            opt_idx_ff <= 6'h00;
            opt_data_ff <= 8'h00;
        end else begin
            // in idle the reset line release takes priority over any bus request; a release during a fetch is dropped
            case (state_ff)
                ST_IDLE: begin
                    if (rise) begin
                        // strap sampled at the release picks the source
                        state_ff <= ST_FETCH;
                        mem_addr <= `RCL_CFG_ADDR;
                        fetch_ext_ff <= strap;
                        mem_rd_int <= ~strap;
                        mem_rd_ext <= strap;
                    end else if (opt_rd_access & opt_valid) begin
                        // option bytes are read-only; no write path exists
                        state_ff <= ST_OPT;
                        mem_addr <= `RCL_OPT_LO + {18'h00000, opt_idx_ff};
                        mem_rd_int <= ~bus_mode;
                        mem_rd_ext <= bus_mode;
                    end else if (wr & (paddr == `RCL_OFF_CFG)) begin
                        cfg_ff <= pwdata[7:0];
                    end else if (wr & (paddr == `RCL_OFF_OPTADDR)) begin
                        opt_idx_ff <= pwdata[5:0];
                    end
                end
                ST_FETCH: begin
                    // config byte lands when storage answers
                    if (mem_ack) begin
                        cfg_ff <= mem_rdata;
                        loaded_ff <= 1'b1;
                        mem_rd_int <= 1'b0;
                        mem_rd_ext <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_OPT: begin
                    // option byte lands; the next read returns it
                    if (mem_ack) begin
                        opt_data_ff <= mem_rdata;
                        mem_rd_int <= 1'b0;
                        mem_rd_ext <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    // unused code returns to idle
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // reset pulse generator; strap read live so the power-on rule tracks it
    // a request while a pulse runs is ignored; a count of zero marks idle
    // the power-on flag clears on the first pulse whatever the strap reads
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_cnt_ff <= 13'd0;
            reset_line_oe <= 1'b0;
            first_pulse_ff <= 1'b1;
        end else if (internal_reset_req & (pulse_cnt_ff == 13'd0)) begin
            reset_line_oe <= 1'b1;
            first_pulse_ff <= 1'b0;
            if (!strap)
                pulse_cnt_ff <= LONG_N;
            else if (first_pulse_ff)
                pulse_cnt_ff <= SHORT_N;
            else
                pulse_cnt_ff <= cfg_ff[`RCL_BIT_RESET_PULSE_LENGTH_SEL] ? LONG_N : SHORT_N;
        end else if (pulse_cnt_ff != 13'd0) begin
            pulse_cnt_ff <= pulse_cnt_ff - 13'd1;
            reset_line_oe <= (pulse_cnt_ff != 13'd1);
        end
    end

    // apb read mux, registered on every read cycle so the access phase sees the setup value
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (rd) begin
            case (paddr)
                `RCL_OFF_CFG: prdata <= {24'h000000, cfg_ff};
                `RCL_OFF_STAT: prdata <= {26'h0, reset_line_oe, loaded_ff, fetch_ext_ff, bus_mode, storage_sel};
                `RCL_OFF_OPTADDR: prdata <= {26'h0, opt_idx_ff};
                `RCL_OFF_OPTDATA: prdata <= {24'h000000, opt_data_ff};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

/* File: rcl_defs.vh */
// constants for the reset configuration byte loader
`ifndef RCL_DEFS_VH
`define RCL_DEFS_VH
`define RCL_CFG_ADDR 24'hfff3
`define RCL_OPT_LO 24'hffa0
`define RCL_OPT_HI 24'hffc3
`define RCL_OPT_LAST 6'd35
`define RCL_OFF_CFG 12'h000
`define RCL_OFF_STAT 12'h004
`define RCL_OFF_OPTADDR 12'h008
`define RCL_OFF_OPTDATA 12'h00c
`define RCL_BIT_RESET_PULSE_LENGTH_SEL 7
`define RCL_BIT_TOG 6
`define RCL_BIT_MODE 4
`define RCL_BIT_FROM 3
`define RCL_BIT_ONCHIP_ROM_SELECT 2
`define RCL_BIT_ONCHIP_RAM_ENABLE 1
`define RCL_BIT_ONCHIP_CPU_ENABLE 0
`define RCL_CFG_RST 8'h00
`define RCL_LONG_CYC 13'd4095
`define RCL_SHORT_CYC 13'd16
`endif

/* File: rcl_loader_assertions.sv */
// port assertions for the config loader
`timescale 1ns/1ns
module rcl_chk #(
    parameter LONG_CYC = 4095,
    parameter SHORT_CYC = 16
) (
    input wire ref_clk,
    input wire nrst,
    input wire reset_line_in,
    input wire reset_line_oe,
    input wire internal_reset_req,
    input wire strap_select,
    input wire mem_rd_int,
    input wire mem_rd_ext,
    input wire mem_ack,
    input wire bus_mode,
    input wire onchip_ram_enable,
    input wire onchip_cpu_enable,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire [23:0] mem_addr,
    input wire [1:0] storage_sel,
    input wire [11:0] paddr,
    input wire [31:0] prdata
);
    reg [12:0] hi_ff;
    wire rd = psel && penable && pready && !pwrite && paddr == 12'h000;
    wire mrd = mem_rd_int || mem_rd_ext;
    // cycles the outgoing pulse has lasted so far
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) hi_ff <= 13'h0;
        else hi_ff <= reset_line_oe ? hi_ff + 13'h1 : 13'h0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_fetch_src: assert property ($rose(reset_line_in) |-> ##[2:4] mem_addr == 24'hfff3
        && mem_rd_ext == strap_select && mem_rd_int != strap_select) else $error("fetch");
    a_rd_held: assert property (mrd && !mem_ack |=> mrd && $stable(mem_addr)) else $error("held");
    a_opt_area: assert property (mrd |-> mem_addr == 24'hfff3 || mem_addr inside {[24'hffa0:24'hffc3]})
        else $error("addr");
    a_pulse_go: assert property ($rose(internal_reset_req) && !reset_line_oe |=> reset_line_oe)
        else $error("go");
    a_pulse_len: assert property ($fell(reset_line_oe) |-> hi_ff == SHORT_CYC || hi_ff == LONG_CYC)
        else $error("len");
    a_pin_mode: assert property (rd |-> bus_mode == !(prdata[4] || prdata[6] && strap_select))
        else $error("mode");
    a_store_sel: assert property (rd |-> storage_sel == (prdata[2] ? {1'b0, !prdata[3]} : 2'h2))
        else $error("sel");
    a_enables: assert property (rd |-> {onchip_ram_enable, onchip_cpu_enable} == prdata[1:0])
        else $error("en");
endmodule
bind rcl_loader rcl_chk #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
) u_chk (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .reset_line_in(reset_line_in),
    .reset_line_oe(reset_line_oe),
    .internal_reset_req(internal_reset_req),
    .strap_select(strap_select),
    .mem_rd_int(mem_rd_int),
    .mem_rd_ext(mem_rd_ext),
    .mem_ack(mem_ack),
    .bus_mode(bus_mode),
    .onchip_ram_enable(onchip_ram_enable),
    .onchip_cpu_enable(onchip_cpu_enable),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .mem_addr(mem_addr),
    .storage_sel(storage_sel),
    .paddr(paddr),
    .prdata(prdata)
);

/* File: rcl_mem.sv */
// storage model: answers wc+1 cycles after a request, data toggles when not answering
`timescale 1ns/1ns
module rcl_mem (
    input wire ref_clk,
    input wire nrst,
    input wire mem_rd_int,
    input wire mem_rd_ext,
    input wire [23:0] mem_addr,
    input wire [3:0] wc,
    output reg mem_ack,
    output reg [7:0] mem_rdata
);
    reg [3:0] w_ff;
    wire go = (mem_rd_int || mem_rd_ext) && !mem_ack && w_ff == wc;
    // never two acks in a row; a request still held after its ack is answered again when the count next reaches wc
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            w_ff <= 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 8'h5a;
        end else begin
            w_ff <= (mem_rd_int || mem_rd_ext) && !go ? w_ff + 4'h1 : 4'h0;
            mem_ack <= go;
            mem_rdata <= !go ? ~mem_rdata : mem_addr != 24'hfff3 ? mem_addr[7:0] : mem_rd_ext ? 8'hab : 8'hff;
        end
    end
endmodule

/* File: test_reset_config_byte_loader.sv */
// self-checking bench for the config loader
`timescale 1ns/1ns
module test_reset_config_byte_loader;
    reg ref_clk = 0, nrst = 0, ext_low = 1, req = 0, strap = 1, psel = 0, penable = 0, pwrite = 0, err;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0, rd;
    reg [3:0] wc = 4'h3;
    // cfg byte beside expected {bus_mode, storage_sel, ram, cpu} with the strap low
    reg [12:0] rows [0:3] = '{{8'h0f, 5'h13}, {8'h07, 5'h17}, {8'h52, 5'h0a}, {8'h40, 5'h18}};
    wire oe, rdi, rde, ack, bm, ram, cpu, pready, pslverr;
    wire [23:0] ma;
    wire [7:0] md;
    wire [1:0] ss;
    wire [31:0] prdata;
    wire pin = ~(oe | ext_low); // open-drain pin, low if either side pulls
    integer n_fail = 0, samples_checked = 0, i, t;
    rcl_loader #(.LONG_CYC(40)) dut (.ref_clk, .nrst, .reset_line_in(pin), .reset_line_oe(oe),
        .internal_reset_req(req), .strap_select(strap), .mem_addr(ma), .mem_rd_int(rdi), .mem_rd_ext(rde),
        .mem_ack(ack), .mem_rdata(md), .bus_mode(bm), .storage_sel(ss), .onchip_ram_enable(ram),
        .onchip_cpu_enable(cpu), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    rcl_mem mem (.ref_clk, .nrst, .mem_rd_int(rdi), .mem_rd_ext(rde), .mem_addr(ma), .wc, .mem_ack(ack),
        .mem_rdata(md));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task chk(input [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, then an idle cycle so no signal is driven twice at one edge
    task bus(input w, input [11:0] a, input [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        t = 0;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++t < 300);
        if (pready !== 1'b1) n_fail++; // the answer never came
        rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task fetch;
        for (t = 0; ack !== 1'b1 && t < 300; t++) @(posedge ref_clk);
        if (t == 300) n_fail++; // storage never answered
        repeat (3) @(posedge ref_clk);
    endtask
    task pulse(input [31:0] len);
        req <= 1'b1;
        @(posedge ref_clk) req <= 1'b0;
        for (t = 0; oe !== 1'b1 && t < 20; t++) @(posedge ref_clk);
        for (t = 0; oe === 1'b1 && t < 5000; t++) @(posedge ref_clk);
        chk(t, len);
        fetch;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard, well past the few hundred cycles the run needs
    initial begin
        #400000 n_fail++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk) ext_low <= 1'b0;
        fetch;
        bus(1'b0, 12'h000, 32'h0);
        chk(rd, 32'hab);
        bus(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1e);
        pulse(32'h10);
        pulse(32'h28);
        bus(1'b1, 12'h000, 32'h2b);
        pulse(32'h10);
        strap <= 1'b0; wc <= 4'h9; ext_low <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_low <= 1'b0;
        fetch;
        bus(1'b0, 12'h000, 32'h0);
        chk(rd, 32'hff);
        bus(1'b1, 12'h000, 32'h7f);
        pulse(32'h28);
        for (i = 0; i < 4; i++) begin
            bus(1'b1, 12'h000, {24'h0, rows[i][12:5]});
            bus(1'b0, 12'h000, 32'h0);
            chk(rd, {24'h0, rows[i][12:5]});
            chk({27'h0, bm, ss, ram, cpu}, {27'h0, rows[i][4:0]});
        end
        strap <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({31'h0, bm}, 32'h0);
        bus(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        bus(1'b1, 12'h008, 32'h5);
        // each read returns the byte of the previous fetch; the write is ignored
        for (i = 0; i < 4; i++) begin
            if (i == 2) bus(1'b1, 12'h00c, 32'h0);
            bus(1'b0, 12'h00c, 32'h0);
            chk(rd, (i < 2) ? 32'h0 : 32'ha5);
        end
        complete_run;
    end
endmodule
